// ### inc/flash_self_program_cfg.svh
// Constants for the flash self-programming controller
`ifndef FLASH_SELF_PROGRAM_CFG_SVH
`define FLASH_SELF_PROGRAM_CFG_SVH

`define FSP_ADDR_W          26
`define FSP_DATA_W          32
`define FSP_BLOCK_W         3
`define FSP_BLOCK_SHIFT     14
`define FSP_BOOT_MSB        16
`define FSP_RAM_BASE        26'h3ffc000
`define FSP_NMI_OFFSET      26'h0000000
`define FSP_MASKABLE_OFFSET 26'h0000004
`define FSP_ERASED_WORD     32'hffffffff
`define FSP_BUSY_NS         100
`define FSP_CLK_NS          10
`define FSP_BUSY_CYCLES     ((`FSP_BUSY_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_CNT_W           8
`define FSP_WORDS           1024
`define FSP_WIDX_W          10

`endif

// ### inc/flash_self_program_pkg.sv
// Types for the flash self-programming controller
package flash_self_program_pkg;

   typedef enum logic [3:0] {
      OP_MACRO_INIT,
      OP_BLOCK_ERASE,
      OP_WORD_PROGRAM,
      OP_BLOCK_VERIFY,
      OP_BLANK_CHECK,
      OP_PROTECT_CHECK,
      OP_INFO_READ,
      OP_INFO_WRITE,
      OP_BOOT_EXCHANGE,
      OP_WORD_READ,
      OP_CHIP_ERASE
   } op_t;

   typedef enum logic [2:0] {
      ST_OK,
      ST_PROTECT_ERR,
      ST_BLANK_ERR,
      ST_VERIFY_ERR,
      ST_PARAM_ERR
   } status_t;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_EXT_PROGRAM,
      MODE_PROHIBITED
   } mode_t;

endpackage : flash_self_program_pkg

// ### hw/flash_pin_sync.sv
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/100ps
module flash_pin_sync (
   // Clock and reset
   input  wire logic CLK_IN,
   input  wire logic RESETN_IN,
   // Pin and synchronised level
   input  wire logic PIN_IN,
   output logic      SYNC_OUT
);
   logic stage1_reg;

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         stage1_reg <= 1'b0;
         SYNC_OUT   <= 1'b0;
      end else begin
         stage1_reg <= PIN_IN;
         SYNC_OUT   <= stage1_reg;
      end
   end
endmodule : flash_pin_sync

// ### hw/flash_self_program_control.sv
// Flash self-programming controller: macro operations, boot swap, vectors
//
// Notes on behaviour
// - Boot swap exchanges physical blocks 0-3 with blocks 4-7 for every access whose address bits 25:17 are zero.
// - While an erase or program runs, instruction fetch from flash is stalled.
// - An NMI during self programming vectors to the internal RAM start address.
// - A maskable interrupt during self programming vectors to RAM start plus four.
// - The protect pin is sampled at reset release and low selects normal mode.
// - Rewriting is blocked unless the protect pin is at the supply level.
// - The macro offers init, erase, program, verify, blank, pin check, info, swap, read.
// - Instruction fetch returns four bytes each clock.
// - A chip erase clears the whole array in one operation.
// - Protect pin high and second mode pin low at release enters external programming.
`timescale 1ns/100ps
`include "flash_self_program_cfg.svh"
module flash_self_program_control
   import flash_self_program_pkg::*;
(
   // Clock and reset
   input  wire logic                     CLK_IN,
   input  wire logic                     RESETN_IN,
   // Mode pins
   input  wire logic                     WRITE_PROTECT_MODE_PIN_IN,
   input  wire logic                     SECOND_MODE_PIN_IN,
   output mode_t                         MODE_OUT,
   // Self-programming session
   input  wire logic                     SELF_PROG_ACTIVE_IN,
   // Macro request
   input  wire logic                     OP_VALID_IN,
   input  op_t                           OP_CODE_IN,
   input  wire logic [`FSP_ADDR_W-1:0]   OP_ADDR_IN,
   input  wire logic [`FSP_DATA_W-1:0]   OP_WDATA_IN,
   output logic                          OP_READY_OUT,
   output logic                          OP_DONE_OUT,
   output status_t                       OP_STATUS_OUT,
   output logic [`FSP_DATA_W-1:0]        OP_RDATA_OUT,
   output logic                          BOOT_SWAPPED_OUT,
   // Instruction fetch
   input  wire logic                     FETCH_REQ_IN,
   input  wire logic [`FSP_ADDR_W-1:0]   FETCH_ADDR_IN,
   output logic                          FETCH_STALL_OUT,
   output logic                          FETCH_VALID_OUT,
   output logic [`FSP_DATA_W-1:0]        FETCH_DATA_OUT,
   // Interrupt vectoring
   input  wire logic                     NMI_IN,
   input  wire logic                     MASKABLE_IRQ_IN,
   input  wire logic [`FSP_ADDR_W-1:0]   NMI_FLASH_VECTOR_IN,
   input  wire logic [`FSP_ADDR_W-1:0]   IRQ_FLASH_VECTOR_IN,
   output logic                          VECTOR_VALID_OUT,
   output logic [`FSP_ADDR_W-1:0]        VECTOR_ADDR_OUT
);
   typedef enum logic [1:0] {S_IDLE, S_BUSY, S_SCAN} state_t;

   // ==========================================================
   // Pin synchronisation and reset-release sampling
   logic protect_sync;
   logic second_sync;
   logic sampled_reg;
   logic [1:0] settle_reg;

   flash_pin_sync u_sync_protect (
      .CLK_IN    (CLK_IN),
      .RESETN_IN (RESETN_IN),
      .PIN_IN    (WRITE_PROTECT_MODE_PIN_IN),
      .SYNC_OUT  (protect_sync)
   );
   flash_pin_sync u_sync_second (
      .CLK_IN    (CLK_IN),
      .RESETN_IN (RESETN_IN),
      .PIN_IN    (SECOND_MODE_PIN_IN),
      .SYNC_OUT  (second_sync)
   );

   // Mode latched once after reset
   // Waits two edges so the synchronisers no longer show their reset level
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         settle_reg  <= 2'h0;
         sampled_reg <= 1'b0;
         MODE_OUT    <= MODE_NORMAL;
      end else begin
         settle_reg <= {settle_reg[0], 1'b1};
         if (settle_reg[1] && !sampled_reg) begin
            sampled_reg <= 1'b1;
            if (!protect_sync)
               MODE_OUT <= MODE_NORMAL;
            else if (!second_sync)
               MODE_OUT <= MODE_EXT_PROGRAM;
            else
               MODE_OUT <= MODE_PROHIBITED;
         end
      end
   end

   // ==========================================================
   // Flash array and boot swap
   logic [`FSP_DATA_W-1:0] mem [0:`FSP_WORDS-1];
   logic [`FSP_DATA_W-1:0] info_reg;
   logic                   swap_reg;
   state_t                 state_reg;
   op_t                    op_reg;
   logic [`FSP_WIDX_W-1:0] idx_reg;
   logic [`FSP_WIDX_W-1:0] end_reg;
   logic [`FSP_DATA_W-1:0] wdata_reg;
   logic [`FSP_CNT_W-1:0]  cnt_reg;
   logic                   fail_reg;

   // Flip the top boot-area bit when swapped
   function automatic logic [`FSP_WIDX_W-1:0] phys(input logic [`FSP_ADDR_W-1:0] a);
      logic [`FSP_ADDR_W-1:0] p;
      p = a;
      if (swap_reg && (a[`FSP_ADDR_W-1:`FSP_BOOT_MSB+1] == '0))
         p[`FSP_BOOT_MSB] = ~a[`FSP_BOOT_MSB];
      phys = {p[`FSP_BOOT_MSB:`FSP_BLOCK_SHIFT], p[`FSP_WIDX_W-`FSP_BLOCK_W+1:2]};
   endfunction : phys

   logic rewrite_op;
   logic protect_ok;
   logic [`FSP_WIDX_W-1:0] op_idx;

   // Word index of the request, after any boot swap
   always_comb begin
      op_idx = phys(OP_ADDR_IN);
   end

   assign rewrite_op = (OP_CODE_IN == OP_BLOCK_ERASE) || (OP_CODE_IN == OP_WORD_PROGRAM)
                     || (OP_CODE_IN == OP_CHIP_ERASE) || (OP_CODE_IN == OP_INFO_WRITE)
                     || (OP_CODE_IN == OP_BOOT_EXCHANGE);
   // Rewrite needs protect pin high during a session
   assign protect_ok = protect_sync;
   assign OP_READY_OUT = (state_reg == S_IDLE);

   // ==========================================================
   // Macro sequencer
   // Operation dispatch
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_reg     <= S_IDLE;
         op_reg        <= OP_MACRO_INIT;
         idx_reg       <= '0;
         end_reg       <= '0;
         wdata_reg     <= '0;
         cnt_reg       <= '0;
         fail_reg      <= 1'b0;
         swap_reg      <= 1'b0;
         info_reg      <= '0;
         OP_DONE_OUT   <= 1'b0;
         OP_STATUS_OUT <= ST_OK;
         OP_RDATA_OUT  <= '0;
      end else begin
         OP_DONE_OUT <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (OP_VALID_IN) begin
                  op_reg    <= OP_CODE_IN;
                  wdata_reg <= OP_WDATA_IN;
                  fail_reg  <= 1'b0;
                  idx_reg   <= {op_idx[`FSP_WIDX_W-1 -: `FSP_BLOCK_W],
                                 {(`FSP_WIDX_W-`FSP_BLOCK_W){1'b0}}};
                  end_reg   <= {op_idx[`FSP_WIDX_W-1 -: `FSP_BLOCK_W],
                                 {(`FSP_WIDX_W-`FSP_BLOCK_W){1'b1}}};
                  cnt_reg   <= `FSP_CNT_W'(`FSP_BUSY_CYCLES);
                  // Refuse rewrite with the pin low
                  if (rewrite_op && !(protect_ok && SELF_PROG_ACTIVE_IN)) begin
                     OP_DONE_OUT   <= 1'b1;
                     OP_STATUS_OUT <= ST_PROTECT_ERR;
                  end else begin
                     case (OP_CODE_IN)
                        OP_BLOCK_ERASE, OP_BLOCK_VERIFY, OP_BLANK_CHECK:
                           state_reg <= S_SCAN;
                        OP_CHIP_ERASE: begin
                           idx_reg   <= '0;
                           end_reg   <= '1;
                           state_reg <= S_SCAN;
                        end
                        OP_WORD_PROGRAM: begin
                           idx_reg   <= phys(OP_ADDR_IN);
                           state_reg <= S_BUSY;
                        end
                        default: begin
                           OP_DONE_OUT   <= 1'b1;
                           OP_STATUS_OUT <= ST_OK;
                           case (OP_CODE_IN)
                              OP_WORD_READ:     OP_RDATA_OUT <= mem[phys(OP_ADDR_IN)];
                              OP_INFO_READ:     OP_RDATA_OUT <= info_reg;
                              OP_INFO_WRITE:    info_reg <= OP_WDATA_IN;
                              OP_BOOT_EXCHANGE: swap_reg <= ~swap_reg;
                              OP_PROTECT_CHECK: begin
                                 OP_RDATA_OUT  <= {{(`FSP_DATA_W-1){1'b0}}, protect_sync};
                                 OP_STATUS_OUT <= protect_sync ? ST_OK : ST_PROTECT_ERR;
                              end
                              default: OP_RDATA_OUT <= OP_RDATA_OUT;
                           endcase
                        end
                     endcase
                  end
               end
            end
            S_BUSY: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - `FSP_CNT_W'(1);
               end else begin
                  mem[idx_reg]  <= mem[idx_reg] & wdata_reg;
                  OP_DONE_OUT   <= 1'b1;
                  OP_STATUS_OUT <= ST_OK;
                  state_reg     <= S_IDLE;
               end
            end
            S_SCAN: begin
               // Chip erase walks the whole array in one request
               if (op_reg == OP_BLOCK_ERASE || op_reg == OP_CHIP_ERASE)
                  mem[idx_reg] <= `FSP_ERASED_WORD;
               else if (op_reg == OP_BLANK_CHECK && mem[idx_reg] != `FSP_ERASED_WORD)
                  fail_reg <= 1'b1;
               if (idx_reg == end_reg) begin
                  OP_DONE_OUT <= 1'b1;
                  if (op_reg == OP_BLANK_CHECK &&
                      (fail_reg || mem[idx_reg] != `FSP_ERASED_WORD))
                     OP_STATUS_OUT <= ST_BLANK_ERR;
                  else
                     OP_STATUS_OUT <= ST_OK;
                  state_reg <= S_IDLE;
               end else begin
                  idx_reg <= idx_reg + `FSP_WIDX_W'(1);
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   assign BOOT_SWAPPED_OUT = swap_reg;

   // ==========================================================
   // Instruction fetch
   logic rewriting;
   assign rewriting = (state_reg != S_IDLE) &&
                      (op_reg == OP_BLOCK_ERASE || op_reg == OP_WORD_PROGRAM ||
                       op_reg == OP_CHIP_ERASE);
   assign FETCH_STALL_OUT = FETCH_REQ_IN && rewriting;

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         FETCH_VALID_OUT <= 1'b0;
         FETCH_DATA_OUT  <= '0;
      end else begin
         FETCH_VALID_OUT <= FETCH_REQ_IN && !rewriting;
         if (FETCH_REQ_IN && !rewriting)
            FETCH_DATA_OUT <= mem[phys(FETCH_ADDR_IN)];
      end
   end

   // ==========================================================
   // Interrupt vectoring, NMI wins
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         VECTOR_VALID_OUT <= 1'b0;
         VECTOR_ADDR_OUT  <= '0;
      end else begin
         VECTOR_VALID_OUT <= NMI_IN || MASKABLE_IRQ_IN;
         if (NMI_IN)
            VECTOR_ADDR_OUT <= SELF_PROG_ACTIVE_IN ? `FSP_RAM_BASE + `FSP_NMI_OFFSET
                                                   : NMI_FLASH_VECTOR_IN;
         else if (MASKABLE_IRQ_IN)
            // Maskable to RAM start plus four
            VECTOR_ADDR_OUT <= SELF_PROG_ACTIVE_IN ? `FSP_RAM_BASE + `FSP_MASKABLE_OFFSET
                                                   : IRQ_FLASH_VECTOR_IN;
      end
   end
endmodule : flash_self_program_control

// ### dv/flash_self_program_control_properties.sv
// Port assertions for the flash self-programming controller
`timescale 1ns/100ps
`include "flash_self_program_cfg.svh"
module flash_self_program_control_properties
   import flash_self_program_pkg::*;
(
   // Clock and reset
   input wire logic                   CLK_IN,
   input wire logic                   RESETN_IN,
   // Macro side
   input wire logic                   SELF_PROG_ACTIVE_IN,
   input wire logic                   OP_VALID_IN,
   input op_t                         OP_CODE_IN,
   input wire logic                   OP_READY_OUT,
   input wire logic                   OP_DONE_OUT,
   input status_t                     OP_STATUS_OUT,
   input wire logic                   BOOT_SWAPPED_OUT,
   // Fetch and vectors
   input wire logic                   FETCH_REQ_IN,
   input wire logic                   FETCH_STALL_OUT,
   input wire logic                   FETCH_VALID_OUT,
   input wire logic                   NMI_IN,
   input wire logic                   MASKABLE_IRQ_IN,
   input wire logic                   VECTOR_VALID_OUT,
   input wire logic [`FSP_ADDR_W-1:0] VECTOR_ADDR_OUT
);
   // ====
   // Properties
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   wire take = OP_VALID_IN && OP_READY_OUT;
   wire perr = OP_STATUS_OUT == ST_PROTECT_ERR;
   property p_done; OP_DONE_OUT && !take |=> !OP_DONE_OUT; endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_refuse;
      take && !SELF_PROG_ACTIVE_IN && OP_CODE_IN inside {OP_BLOCK_ERASE, OP_WORD_PROGRAM}
         |=> OP_DONE_OUT && perr;
   endproperty
   a_refuse: assert property (p_refuse) else $error("rewrite not refused");
   property p_prog;
      take && OP_CODE_IN == OP_WORD_PROGRAM |=> (OP_DONE_OUT && perr) or (!OP_DONE_OUT ##11 OP_DONE_OUT);
   endproperty
   a_prog: assert property (p_prog) else $error("program time");
   property p_swap;
      take && OP_CODE_IN == OP_BOOT_EXCHANGE
         |=> OP_DONE_OUT && (perr || BOOT_SWAPPED_OUT != $past(BOOT_SWAPPED_OUT));
   endproperty
   a_swap: assert property (p_swap) else $error("swap not toggled");
   property p_nmi;
      $rose(NMI_IN) && SELF_PROG_ACTIVE_IN
         |=> VECTOR_VALID_OUT && VECTOR_ADDR_OUT == `FSP_RAM_BASE + `FSP_NMI_OFFSET;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi vector");
   property p_irq;
      $rose(MASKABLE_IRQ_IN) && !NMI_IN && SELF_PROG_ACTIVE_IN
         |=> VECTOR_VALID_OUT && VECTOR_ADDR_OUT == `FSP_RAM_BASE + `FSP_MASKABLE_OFFSET;
   endproperty
   a_irq: assert property (p_irq) else $error("irq vector");
   property p_fetch; FETCH_REQ_IN && !FETCH_STALL_OUT |=> FETCH_VALID_OUT; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch late");
   property p_stall; FETCH_STALL_OUT |=> !FETCH_VALID_OUT; endproperty
   a_stall: assert property (p_stall) else $error("fetch during rewrite");
   property p_cause; FETCH_STALL_OUT |-> FETCH_REQ_IN && !OP_READY_OUT; endproperty
   a_cause: assert property (p_cause) else $error("stall without cause");
   c_prog: cover property (take && OP_CODE_IN == OP_WORD_PROGRAM);
   c_stall: cover property (FETCH_STALL_OUT);
   c_vec: cover property (VECTOR_VALID_OUT);
endmodule : flash_self_program_control_properties

// ### dv/tb_flash_self_program_control.sv
// Self-checking bench for the flash self-programming controller
`timescale 1ns/100ps
`include "flash_self_program_cfg.svh"
module tb_flash_self_program_control
   import flash_self_program_pkg::*;
();
   // ====
   // Stimulus and model state
   logic clk, rstn = 0, wp = 0, m2 = 0, act = 0, vld = 0, freq = 0, nmi = 0, irq = 0;
   op_t code = OP_MACRO_INIT;
   logic [25:0] addr = 0, faddr = 0, nv = 0, iv = 0, va;
   logic [31:0] wd = 0, rd, fd, rdv, dat, mem [int];
   mode_t mode;
   status_t st, stv;
   logic rdy, done, swo, stall, fv, vv, sw = 0;
   int fails = 0, n_compared = 0;
   localparam logic [25:0] A = 26'h0000104, B = 26'h0010104;
   flash_self_program_control flash_self_program_control_i (
      .CLK_IN(clk), .RESETN_IN(rstn), .WRITE_PROTECT_MODE_PIN_IN(wp),
      .SECOND_MODE_PIN_IN(m2), .MODE_OUT(mode), .SELF_PROG_ACTIVE_IN(act),
      .OP_VALID_IN(vld), .OP_CODE_IN(code), .OP_ADDR_IN(addr), .OP_WDATA_IN(wd),
      .OP_READY_OUT(rdy), .OP_DONE_OUT(done), .OP_STATUS_OUT(st), .OP_RDATA_OUT(rd),
      .BOOT_SWAPPED_OUT(swo), .FETCH_REQ_IN(freq), .FETCH_ADDR_IN(faddr),
      .FETCH_STALL_OUT(stall), .FETCH_VALID_OUT(fv), .FETCH_DATA_OUT(fd), .NMI_IN(nmi),
      .MASKABLE_IRQ_IN(irq), .NMI_FLASH_VECTOR_IN(nv), .IRQ_FLASH_VECTOR_IN(iv),
      .VECTOR_VALID_OUT(vv), .VECTOR_ADDR_OUT(va));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ====
   // Tasks
   task automatic test_done();
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic int ix(input logic [25:0] a);
      return {a[16] ^ sw, a[15:14], a[8:2]};
   endfunction : ix
   task automatic op(input op_t c, input logic [25:0] a, input logic [31:0] d, input int lim);
      int i;
      @(posedge clk);
      vld <= 1'b1;
      code <= c;
      addr <= a;
      wd <= d;
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         if (rdy === 1'b1) break;
      end
      vld <= 1'b0;
      if (i == 4)
         chk("op_ready", 32'h1, 32'h0);
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      if (i == lim) begin
         chk("op_done", 32'h1, 32'h0);
         test_done();
      end
      stv = st;
      rdv = rd;
   endtask : op
   task automatic rdchk(input logic [25:0] a);
      op(OP_WORD_READ, a, 32'h0, 4);
      chk("word_read", mem[ix(a)], rdv);
      freq <= 1'b1;
      faddr <= a;
      @(posedge clk);
      freq <= 1'b0;
      @(posedge clk);
      chk("fetch_valid", 32'h1, {31'h0, fv});
      chk("fetch_data", mem[ix(a)], fd);
   endtask : rdchk
   task automatic vec(input logic n, input logic [25:0] e);
      @(posedge clk);
      nmi <= n;
      irq <= 1'b1;
      @(posedge clk);
      nmi <= 1'b0;
      irq <= 1'b0;
      @(posedge clk);
      chk("vec_valid", 32'h1, {31'h0, vv});
      chk("vec_addr", 32'(e), 32'(va));
   endtask : vec
   // ====
   // Main sequence
   initial begin
      void'($urandom(67492));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      act <= 1'b1;
      repeat (4) @(posedge clk);
      chk("mode", 32'(MODE_NORMAL), 32'(mode));
      wp <= 1'b1;
      repeat (3) @(posedge clk);
      op(OP_MACRO_INIT, A, 0, 4);
      chk("init", 32'(ST_OK), 32'(stv));
      op(OP_PROTECT_CHECK, A, 0, 4);
      chk("pin", 32'h1, {31'h0, rdv[0]});
      // No info write or exchange before rewriting
      op(OP_BLOCK_ERASE, A, 0, 300);
      op(OP_BLOCK_ERASE, B, 0, 300);
      for (int i = 0; i < 128; i++) begin
         mem[i] = '1;
         mem[512 + i] = '1;
      end
      op(OP_BLANK_CHECK, A, 0, 300);
      chk("blank", 32'(ST_OK), 32'(stv));
      dat = $urandom();
      fork
         op(OP_WORD_PROGRAM, A, dat, 20);
         begin
            repeat (4) @(posedge clk);
            freq <= 1'b1;
            @(posedge clk);
            chk("stall", 32'h1, {31'h0, stall});
            freq <= 1'b0;
         end
      join
      mem[ix(A)] = mem[ix(A)] & dat;
      op(OP_BLANK_CHECK, A, 0, 300);
      chk("blank_fail", 32'(ST_BLANK_ERR), 32'(stv));
      op(OP_BLOCK_VERIFY, A, 0, 300);
      chk("verify", 32'(ST_OK), 32'(stv));
      rdchk(A);
      dat = $urandom();
      op(OP_INFO_WRITE, A, dat, 4);
      op(OP_INFO_READ, A, 0, 4);
      chk("info", dat, rdv);
      op(OP_BOOT_EXCHANGE, A, 0, 4);
      sw = 1'b1;
      chk("swapped", 32'h1, {31'h0, swo});
      rdchk(A);
      rdchk(B);
      wp <= 1'b0;
      repeat (3) @(posedge clk);
      op(OP_WORD_PROGRAM, B, 32'h0, 20);
      chk("prog_lowpin", 32'(ST_PROTECT_ERR), 32'(stv));
      rdchk(B);
      wp <= 1'b1;
      act <= 1'b0;
      nv <= 26'($urandom());
      iv <= 26'($urandom());
      repeat (3) @(posedge clk);
      op(OP_BLOCK_ERASE, A, 0, 300);
      chk("erase_idle", 32'(ST_PROTECT_ERR), 32'(stv));
      vec(1'b1, nv);
      vec(1'b0, iv);
      // Handler jumps taken as placed in RAM
      act <= 1'b1;
      vec(1'b1, `FSP_RAM_BASE + `FSP_NMI_OFFSET);
      vec(1'b0, `FSP_RAM_BASE + `FSP_MASKABLE_OFFSET);
      op(OP_CHIP_ERASE, A, 0, 20000);
      chk("chip_erase", 32'(ST_OK), 32'(stv));
      for (int i = 0; i < 1024; i++)
         mem[i] = '1;
      rdchk(B);
      for (int k = 0; k < 2; k++) begin
         m2 <= k[0];
         rstn <= 1'b0;
         repeat (3) @(posedge clk);
         rstn <= 1'b1;
         repeat (5) @(posedge clk);
         chk("mode_pins", k ? 32'(MODE_PROHIBITED) : 32'(MODE_EXT_PROGRAM), 32'(mode));
      end
      test_done();
   end
endmodule : tb_flash_self_program_control

bind flash_self_program_control flash_self_program_control_properties
   flash_self_program_control_properties_i (.CLK_IN, .RESETN_IN, .SELF_PROG_ACTIVE_IN,
   .OP_VALID_IN, .OP_CODE_IN, .OP_READY_OUT, .OP_DONE_OUT, .OP_STATUS_OUT, .BOOT_SWAPPED_OUT,
   .FETCH_REQ_IN, .FETCH_STALL_OUT, .FETCH_VALID_OUT, .NMI_IN, .MASKABLE_IRQ_IN,
   .VECTOR_VALID_OUT, .VECTOR_ADDR_OUT);
